//--- gdrv_host_model.sv
// Purpose: serial host that owns the link clock and runs one frame per call
// Assumes: clock low when idle and at select edges; shift on rise, sample on fall
// Notes: after a frame the data line shows the inverse of its last bit
module gdrv_host_model (
    // link pins
    output logic SCLK,
    output logic CS_N,
    output logic SDI,
    input wire logic SDO
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lclk = 1'b0;

    // free 12 ns reference, phase unrelated to the core clock
    initial begin
        #3.3;
        forever #6 lclk = ~lclk;
    end

    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SDI = 1'b0;
    end

    // nbits other than 16 makes a frame the device must drop
    task automatic xfer(input logic [15:0] fr, input int nbits, output logic [15:0] rsp);
        int i;
        rsp = 16'h0000;
        @(posedge lclk);
        CS_N <= 1'b0;
        for (i = 0; i < nbits; i++) begin
            @(posedge lclk);
            SCLK <= 1'b1;
            SDI <= fr[15-i];
            @(negedge lclk);
            SCLK <= 1'b0;
            rsp = {rsp[14:0], SDO};
        end
        @(posedge lclk);
        CS_N <= 1'b1;
        SDI <= ~SDI;
        // select stays high well over 500 ns between frames
        repeat (45) @(posedge lclk);
    endtask
endmodule

//--- gdrv_link_if.sv
// Purpose: carries one completed frame from the link domain to the core domain
// Assumes: the frame stays stable until the next toggle
// Notes: toggle handshake; the core acknowledges nothing, frames are at least 756 ns apart
interface gdrv_link_if;
    logic frame_tgl;
    logic [15:0] frame;
    logic [10:0] rsp_word;
    modport link (output frame_tgl, output frame, input rsp_word);
    modport core (input frame_tgl, input frame, output rsp_word);
endinterface

//--- gdrv_pkg.sv
// Purpose: shared constants for the gate driver status and drive-strength registers
// Assumes: 16-bit serial frames, 4-bit address, 11-bit register words
// Notes: reserved positions are given as masks so reads return zero there
package gdrv_pkg;
    localparam int WORD_W = 11;
    localparam int ADDR_W = 4;
    localparam int FRAME_W = 16;
    localparam int FRAME_CNT_W = 5;
    typedef logic [WORD_W-1:0] word_t;
    typedef logic [ADDR_W-1:0] addr_t;

    localparam addr_t ADDR_WARN = 4'h1;
    localparam addr_t ADDR_OCF = 4'h2;
    localparam addr_t ADDR_CHIPF = 4'h3;
    localparam addr_t ADDR_GSF = 4'h4;
    localparam addr_t ADDR_HSDRV = 4'h5;
    localparam addr_t ADDR_LSDRV = 4'h6;

    // frame field positions
    localparam int FRM_RW_POS = 15;
    localparam int FRM_ADDR_LSB = 11;

    // warning word bits
    localparam int WARN_FAULT_POS = 10;
    localparam int WARN_T175_POS = 8;
    localparam int WARN_PSLOW_POS = 7;
    localparam int WARN_PSHIGH_POS = 6;
    localparam int WARN_DSOR_POS = 5;
    localparam int WARN_PUMPLOW_POS = 4;
    localparam int WARN_T105_POS = 3;
    localparam int WARN_T125_POS = 2;
    localparam int WARN_T135_POS = 1;
    localparam int WARN_OTW_POS = 0;

    // overcurrent word
    localparam int OCF_DS_LSB = 5;
    localparam int OCF_SENSE_LSB = 0;

    // chip fault word bits
    localparam int CF_PSLOCK_POS = 10;
    localparam int CF_WDOG_POS = 9;
    localparam int CF_OVERHEAT_SHUTDOWN_FAULT_POS = 8;
    localparam int CF_REG_POS = 6;
    localparam int CF_ANALOG_POS = 5;
    localparam int CF_LSSUP_POS = 4;
    localparam int CF_PUMPLOW_POS = 2;
    localparam int CF_PUMPHIGH_POS = 1;
    localparam int CF_PUMPABS_POS = 0;

    // gate-source word
    localparam int GSF_LSB = 5;

    // drive word fields
    localparam int DRV_TIME_LSB = 8;
    localparam int DRV_SINK_LSB = 4;
    localparam int DRV_SOURCE_LSB = 0;

    localparam word_t STATUS_RESET = 11'h000;
    localparam word_t HSDRV_RESET = 11'h344;
    localparam word_t LSDRV_RESET = 11'h344;
    localparam word_t DRV_WRITE_MASK = 11'h3FF;
    localparam word_t WARN_MASK = 11'h5FF;
    localparam word_t OCF_MASK = 11'h7E7;
    localparam word_t CHIPF_MASK = 11'h777;
    localparam word_t GSF_MASK = 11'h7E0;
endpackage

//--- gdrv_regs.sv
// Purpose: status and gate-drive strength register bank behind a serial slave link
// Assumes: fault inputs are asynchronous levels; sclk is the link clock from the host
// Notes: every frame, read or write, returns the word addressed by the last accepted 16-bit frame
module gdrv_regs
    import gdrv_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // serial link
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE_N,
    // warning monitors
    input wire logic [10:0] WARN_IN,
    // drain-source monitors, high A first
    input wire logic [5:0] DS_FAULT_IN,
    // sense overcurrent C, B, A
    input wire logic [2:0] SENSE_FAULT_IN,
    // chip fault monitors at their word positions
    input wire logic [10:0] CHIP_FAULT_IN,
    // gate-source monitors, high A first
    input wire logic [5:0] GS_FAULT_IN,
    // control events
    input wire logic SLEEP_ENTER,
    input wire logic FAULT_CLEAR_COMMAND,
    // outputs
    output logic WATCHDOG_KICK,
    output logic [1:0] HIGH_SIDE_SOURCE_TIME,
    output logic [3:0] HIGH_SIDE_SINK_CURRENT,
    output logic [3:0] HIGH_SIDE_SOURCE_CURRENT,
    output logic [1:0] LOW_SIDE_SOURCE_TIME,
    output logic [3:0] LOW_SIDE_SINK_CURRENT,
    output logic [3:0] LOW_SIDE_SOURCE_CURRENT
);
    import gdrv_pkg::*;

    gdrv_link_if lk ();

    gdrv_serial_link u_link (
        .rst_n(RESETN),
        .sclk(SCLK),
        .cs_n(CS_N),
        .sdi(SDI),
        .sdo(SDO),
        .sdo_oe_n(SDO_OE_N),
        .lk(lk.link)
    );

    // two-flop synchronisers for asynchronous monitors
    logic [10:0] warn_s1_r, warn_s2_r;
    logic [5:0] ds_s1_r, ds_s2_r;
    logic [2:0] sns_s1_r, sns_s2_r;
    logic [10:0] chip_s1_r, chip_s2_r;
    logic [5:0] gs_s1_r, gs_s2_r;
    logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
    logic cs_s1_r, cs_s2_r;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            warn_s1_r <= 11'h000;
            warn_s2_r <= 11'h000;
            ds_s1_r <= 6'h00;
            ds_s2_r <= 6'h00;
            sns_s1_r <= 3'h0;
            sns_s2_r <= 3'h0;
            chip_s1_r <= 11'h000;
            chip_s2_r <= 11'h000;
            gs_s1_r <= 6'h00;
            gs_s2_r <= 6'h00;
        end else begin
            warn_s1_r <= WARN_IN;
            warn_s2_r <= warn_s1_r;
            ds_s1_r <= DS_FAULT_IN;
            ds_s2_r <= ds_s1_r;
            sns_s1_r <= SENSE_FAULT_IN;
            sns_s2_r <= sns_s1_r;
            chip_s1_r <= CHIP_FAULT_IN;
            chip_s2_r <= chip_s1_r;
            gs_s1_r <= GS_FAULT_IN;
            gs_s2_r <= gs_s1_r;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
        end else begin
            cs_s1_r <= CS_N;
            cs_s2_r <= cs_s1_r;
            tgl_s1_r <= lk.frame_tgl;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    logic frame_done;
    logic frame_rd;
    addr_t frame_addr;
    word_t frame_data;
    assign frame_done = tgl_s2_r ^ tgl_s3_r;
    assign frame_rd = lk.frame[FRM_RW_POS];
    assign frame_addr = lk.frame[FRM_RW_POS-1:FRM_ADDR_LSB];
    assign frame_data = lk.frame[WORD_W-1:0];

    // latched fault words: set wins over clear
    logic [5:0] ds_lat_r;
    logic [2:0] sns_lat_r;
    logic [10:0] chip_lat_r;
    logic [5:0] gs_lat_r;
    logic clear_s1_r, clear_s2_r;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            clear_s1_r <= 1'b0;
            clear_s2_r <= 1'b0;
        end else begin
            clear_s1_r <= FAULT_CLEAR_COMMAND;
            clear_s2_r <= clear_s1_r;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ds_lat_r <= 6'h00;
            sns_lat_r <= 3'h0;
            chip_lat_r <= 11'h000;
            gs_lat_r <= 6'h00;
        end else if (clear_s2_r) begin
            ds_lat_r <= ds_s2_r;
            sns_lat_r <= sns_s2_r;
            chip_lat_r <= chip_s2_r & CHIPF_MASK;
            gs_lat_r <= gs_s2_r;
        end else begin
            ds_lat_r <= ds_lat_r | ds_s2_r;
            sns_lat_r <= sns_lat_r | sns_s2_r;
            chip_lat_r <= chip_lat_r | (chip_s2_r & CHIPF_MASK);
            gs_lat_r <= gs_lat_r | gs_s2_r;
        end
    end

    // status words assembled; reserved positions held at zero
    word_t warn_word, ocf_word, chipf_word, gsf_word;
    logic any_fault;
    assign any_fault = (|ds_lat_r) | (|sns_lat_r) | (|chip_lat_r) | (|gs_lat_r);

    always_comb begin
        warn_word = warn_s2_r & WARN_MASK;
        warn_word[WARN_DSOR_POS] = |ds_s2_r;
        warn_word[WARN_FAULT_POS] = any_fault;
        ocf_word = STATUS_RESET;
        ocf_word[OCF_DS_LSB +: 6] = ds_lat_r;
        ocf_word[OCF_SENSE_LSB +: 3] = sns_lat_r;
        chipf_word = chip_lat_r & CHIPF_MASK;
        gsf_word = STATUS_RESET;
        gsf_word[GSF_LSB +: 6] = gs_lat_r;
    end

    // drive-strength words
    word_t hs_drv_r, ls_drv_r;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            hs_drv_r <= HSDRV_RESET;
            ls_drv_r <= LSDRV_RESET;
        end else if (SLEEP_ENTER) begin
            hs_drv_r <= HSDRV_RESET;
            ls_drv_r <= LSDRV_RESET;
        end else if (frame_done && !frame_rd) begin
            if (frame_addr == ADDR_HSDRV) begin
                hs_drv_r <= frame_data & DRV_WRITE_MASK;
            end
            if (frame_addr == ADDR_LSDRV) begin
                ls_drv_r <= frame_data & DRV_WRITE_MASK;
            end
        end
    end

    // drive words change only on the reset, write and sleep paths above
    assign HIGH_SIDE_SOURCE_TIME = hs_drv_r[DRV_TIME_LSB +: 2];
    assign HIGH_SIDE_SINK_CURRENT = hs_drv_r[DRV_SINK_LSB +: 4];
    assign HIGH_SIDE_SOURCE_CURRENT = hs_drv_r[DRV_SOURCE_LSB +: 4];
    assign LOW_SIDE_SOURCE_TIME = ls_drv_r[DRV_TIME_LSB +: 2];
    assign LOW_SIDE_SINK_CURRENT = ls_drv_r[DRV_SINK_LSB +: 4];
    assign LOW_SIDE_SOURCE_CURRENT = ls_drv_r[DRV_SOURCE_LSB +: 4];

    // response word, read mux
    function automatic word_t read_mux(input addr_t a, input word_t w0, input word_t w1,
                                       input word_t w2, input word_t w3,
                                       input word_t w4, input word_t w5);
        case (a)
            ADDR_WARN: read_mux = w0;
            ADDR_OCF: read_mux = w1;
            ADDR_CHIPF: read_mux = w2;
            ADDR_GSF: read_mux = w3;
            ADDR_HSDRV: read_mux = w4;
            ADDR_LSDRV: read_mux = w5;
            default: read_mux = STATUS_RESET;
        endcase
    endfunction

    // the answer goes out in the frame after the address is known,
    // so the response names the last addressed word
    word_t rsp_r;
    addr_t last_addr_r;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            last_addr_r <= ADDR_WARN;
        end else if (frame_done) begin
            last_addr_r <= frame_addr;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rsp_r <= STATUS_RESET;
        end else if (cs_s2_r) begin
            rsp_r <= read_mux(last_addr_r, warn_word, ocf_word, chipf_word, gsf_word,
                              hs_drv_r, ls_drv_r);
        end
    end
    assign lk.rsp_word = rsp_r;

    // watchdog service pulse on any status read
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            WATCHDOG_KICK <= 1'b0;
        end else begin
            WATCHDOG_KICK <= frame_done && frame_rd &&
                             frame_addr >= ADDR_WARN && frame_addr <= ADDR_GSF;
        end
    end

    AST_DS_OR: assert property (@(posedge CLK) disable iff (!RESETN)
        warn_word[WARN_DSOR_POS] == (|ds_s2_r)) else $error("live or wrong");
    AST_RSVD: assert property (@(posedge CLK) disable iff (!RESETN)
        (ocf_word[4:3] == 2'h0) && (gsf_word[4:0] == 5'h00) && !warn_word[9])
        else $error("reserved bit set");
    AST_SLEEP: assert property (@(posedge CLK) disable iff (!RESETN)
        SLEEP_ENTER |=> hs_drv_r == HSDRV_RESET && ls_drv_r == LSDRV_RESET)
        else $error("sleep reload");
    AST_STABLE: assert property (@(posedge CLK) disable iff (!RESETN)
        !SLEEP_ENTER && !frame_done |=> $stable(hs_drv_r) && $stable(ls_drv_r))
        else $error("drive word disturbed");
    AST_WRITE: assert property (@(posedge CLK) disable iff (!RESETN)
        frame_done && !frame_rd && !SLEEP_ENTER && frame_addr == ADDR_HSDRV
        |=> hs_drv_r == (DRV_WRITE_MASK & $past(frame_data))) else $error("write");
    AST_KICK: assert property (@(posedge CLK) disable iff (!RESETN)
        frame_done && frame_rd && frame_addr == ADDR_OCF |=> WATCHDOG_KICK)
        else $error("no kick");
    AST_CLEAR: assert property (@(posedge CLK) disable iff (!RESETN)
        clear_s2_r && ds_s2_r == 6'h00 |=> ds_lat_r == 6'h00) else $error("clear");
    AST_STICKY: assert property (@(posedge CLK) disable iff (!RESETN)
        !clear_s2_r && ds_s2_r[5] |=> ocf_word[10]) else $error("fault lost");
endmodule

//--- gdrv_regs_tb_top.sv
// Purpose: self-checking bench for the status and drive-strength register bank
// Assumes: answers lag one frame, so a read is sent twice
// Notes: latched faults are modelled set-wins, cleared to live values
module gdrv_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import gdrv_pkg::*;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic SCLK, CS_N, SDI, SDO, SDO_OE_N, WATCHDOG_KICK;
    logic [10:0] WARN_IN = '0, CHIP_FAULT_IN = '0;
    logic [5:0] DS_FAULT_IN = '0, GS_FAULT_IN = '0;
    logic [2:0] SENSE_FAULT_IN = '0;
    logic SLEEP_ENTER = 1'b0, FAULT_CLEAR_COMMAND = 1'b0;
    logic [1:0] hs_t, ls_t;
    logic [3:0] hs_k, hs_s, ls_k, ls_s;
    int num_errors = 0, checks = 0, kicks = 0, seed = 22558, i;
    word_t e_ocf = '0, e_chip = '0, e_gs = '0, e_hs, e_ls, r;
    logic [31:0] rv;

    always #2 CLK = ~CLK;
    always @(posedge CLK) if (WATCHDOG_KICK === 1'b1) kicks <= kicks + 1;

    gdrv_host_model host (.SCLK(SCLK), .CS_N(CS_N), .SDI(SDI), .SDO(SDO));
    gdrv_regs DUT (.CLK(CLK), .RESETN(RESETN), .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI),
        .SDO(SDO), .SDO_OE_N(SDO_OE_N), .WARN_IN(WARN_IN), .DS_FAULT_IN(DS_FAULT_IN),
        .SENSE_FAULT_IN(SENSE_FAULT_IN), .CHIP_FAULT_IN(CHIP_FAULT_IN),
        .GS_FAULT_IN(GS_FAULT_IN), .SLEEP_ENTER(SLEEP_ENTER),
        .FAULT_CLEAR_COMMAND(FAULT_CLEAR_COMMAND), .WATCHDOG_KICK(WATCHDOG_KICK),
        .HIGH_SIDE_SOURCE_TIME(hs_t), .HIGH_SIDE_SINK_CURRENT(hs_k),
        .HIGH_SIDE_SOURCE_CURRENT(hs_s), .LOW_SIDE_SOURCE_TIME(ls_t),
        .LOW_SIDE_SINK_CURRENT(ls_k), .LOW_SIDE_SOURCE_CURRENT(ls_s));

    task automatic check(input word_t got, input word_t exp);
        checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic frame(input logic rd, input addr_t a, input word_t d, output word_t q);
        logic [15:0] raw;
        host.xfer({rd, a, d}, 16, raw);
        q = raw[10:0];
    endtask

    // second frame answers the address of the first
    task automatic rd(input addr_t a, output word_t q);
        frame(1'b1, a, 11'h000, q);
        frame(1'b1, a, 11'h000, q);
    endtask

    function automatic word_t exp_st(input addr_t a);
        case (a)
            ADDR_OCF: return e_ocf;
            ADDR_CHIPF: return e_chip;
            ADDR_GSF: return e_gs;
            default: return (WARN_IN & 11'h1DF) | {5'h00, |DS_FAULT_IN, 5'h00}
                | {|(e_ocf | e_chip | e_gs), 10'h000};
        endcase
    endfunction

    task automatic set_in(input logic [31:0] a, input logic [31:0] b);
        @(posedge CLK);
        {SENSE_FAULT_IN, DS_FAULT_IN, WARN_IN} <= a[19:0];
        {GS_FAULT_IN, CHIP_FAULT_IN} <= b[16:0];
        repeat (10) @(posedge CLK);
        e_ocf = e_ocf | {DS_FAULT_IN, 2'b00, SENSE_FAULT_IN};
        e_chip = e_chip | (CHIP_FAULT_IN & CHIPF_MASK);
        e_gs = e_gs | {GS_FAULT_IN, 5'h00};
    endtask

    task automatic chk_status();
        int k, a;
        for (a = 1; a <= 4; a++) begin
            k = kicks;
            rd(addr_t'(a), r);
            check(r, exp_st(addr_t'(a)));
            check(word_t'(kicks - k), 11'h002);
        end
    endtask

    task automatic chk_drive();
        int k;
        k = kicks;
        rd(ADDR_HSDRV, r);
        check(r, e_hs);
        rd(ADDR_LSDRV, r);
        check(r, e_ls);
        check(word_t'(kicks - k), 11'h000);
        check({1'b0, hs_t, hs_k, hs_s}, e_hs);
        check({1'b0, ls_t, ls_k, ls_s}, e_ls);
        check({10'h000, SDO_OE_N}, 11'h001);
    endtask

    task automatic wr_drive();
        rv = $random(seed);
        frame(1'b0, ADDR_HSDRV, rv[10:0], r);
        e_hs = rv[10:0] & DRV_WRITE_MASK;
        frame(1'b0, ADDR_LSDRV, rv[26:16], r);
        e_ls = rv[26:16] & DRV_WRITE_MASK;
    endtask

    initial begin
        #200us;
        num_errors++;
        complete_run();
    end

    initial begin
        e_hs = HSDRV_RESET;
        e_ls = LSDRV_RESET;
        repeat (10) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (4) @(posedge CLK);
        chk_drive();
        chk_status();
        for (i = 0; i < 6; i++) begin
            set_in($random(seed), $random(seed));
            chk_status();
            wr_drive();
            chk_drive();
        end
        // writes to read-only words and a dropped short frame
        frame(1'b0, ADDR_OCF, 11'h7FF, r);
        frame(1'b0, ADDR_WARN, 11'h7FF, r);
        host.xfer({1'b0, ADDR_HSDRV, 11'h0AA}, 15, rv[15:0]);
        chk_status();
        chk_drive();
        // latched faults survive the monitors going quiet
        set_in($random(seed) | 32'h000FF800, $random(seed) | 32'h0001F777);
        set_in(32'h0, 32'h0);
        chk_status();
        @(posedge CLK);
        FAULT_CLEAR_COMMAND <= 1'b1;
        repeat (4) @(posedge CLK);
        FAULT_CLEAR_COMMAND <= 1'b0;
        repeat (10) @(posedge CLK);
        e_ocf = '0;
        e_chip = '0;
        e_gs = '0;
        chk_status();
        chk_drive();
        @(posedge CLK);
        SLEEP_ENTER <= 1'b1;
        repeat (2) @(posedge CLK);
        SLEEP_ENTER <= 1'b0;
        repeat (4) @(posedge CLK);
        e_hs = HSDRV_RESET;
        e_ls = LSDRV_RESET;
        chk_drive();
        wr_drive();
        chk_drive();
        @(posedge CLK);
        RESETN <= 1'b0;
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (4) @(posedge CLK);
        e_hs = HSDRV_RESET;
        e_ls = LSDRV_RESET;
        chk_drive();
        chk_status();
        complete_run();
    end
endmodule

//--- gdrv_serial_link.sv
// Purpose: serial slave shift logic on the link clock, mode CPOL 0 CPHA 1
// Assumes: link clock runs only inside frames; shift out on rise, capture on fall
// Notes: the response word is sampled at frame start from the core's quasi-static copy
module gdrv_serial_link
    import gdrv_pkg::*;
(
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    gdrv_link_if.link lk
);
    logic [15:0] shift_in_r;
    logic [4:0] bit_cnt_r;
    logic [15:0] shift_out_r;
    logic tgl_r;
    logic [15:0] frame_r;

    assign sdo_oe_n = cs_n;
    assign sdo = shift_out_r[15];
    assign lk.frame_tgl = tgl_r;
    assign lk.frame = frame_r;

    // capture on falling edge; counter cleared while deselected
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_r <= 5'h00;
            shift_in_r <= 16'h0000;
        end else begin
            shift_in_r <= {shift_in_r[14:0], sdi};
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // frame is complete once 16 bits are in; extra bits are a frame error
    // reset keeps the toggle in step with the core's synchroniser
    always_ff @(posedge cs_n or negedge rst_n) begin
        if (!rst_n) begin
            tgl_r <= 1'b0;
            frame_r <= 16'h0000;
        end else if (bit_cnt_r == 5'h10) begin
            frame_r <= shift_in_r;
            tgl_r <= ~tgl_r;
        end
    end

    // launch on rising edge; first rise presents bit 15 of the current word
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            shift_out_r <= 16'h0000;
        end else if (bit_cnt_r == 5'h00) begin
            shift_out_r <= {5'h00, lk.rsp_word};
        end else begin
            shift_out_r <= {shift_out_r[14:0], 1'b0};
        end
    end
endmodule
